// >>> mis_irq_top.sv
// Interrupt source logic: seven sticky request flags, enables and AXI4-Lite registers
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Contract
// R1 - Timer 0 count wrapping between its limits sets the timer 0 flag.
// R2 - Timer 0 request presented only with its enable and global enable set.
// R3 - Timer 1 count going from maximum to zero sets timer 1 flag.
// R4 - Timer 1 request presented only with its enable and global enable set.
// R5 - Timer 2 count going from maximum to zero sets timer 2 flag.
// R6 - Timer 2 request presented only with its enable and global enable set.
// R7 - Watchdog timeout sets its flag only when configured for interrupt action.
// R8 - Watchdog request presented only with its enable and global enable set.
// R9 - Level change on enabled input port B pins sets the shared change flag.
// R10 - Port B change request presented only with both enables set.
// R11 - External select excludes port B pin zero from change detection.
// R12 - With external select, chosen edge on pin zero sets external flag.
// R13 - External request presented only with its enable and global enable set.
// R14 - Comparator flag set while live output differs from registered copy.
// R15 - Comparator request presented only with its enable and global enable set.
// R16 - Reading oscillator/comparator register copies live comparator output into copy.
// R17 - Flags stay set until written with zero; writing one leaves them.
// R18 - Taken request yields hardware vector and clears the global enable.
// R19 - Pins are synchronised first so one transition sets a flag once.
// R20 - Hardware set wins over firmware clear in the same cycle.
module mis_irq_top
  import mis_pkg::*;
#(
  parameter int PB_W = mis_pkg::MIS_PB_W
) (
  input  wire logic                          CLK,              // System clock
  input  wire logic                          RESET,            // Synchronous reset, high
  input  wire logic                          CE,               // Clock enable
  // AXI4-Lite slave
  input  wire logic [mis_pkg::MIS_AXI_AW-1:0] S_AXI_AWADDR,    // Write address
  input  wire logic                          S_AXI_AWVALID,    // Write address valid
  output logic                               S_AXI_AWREADY,    // Write address ready
  input  wire logic [mis_pkg::MIS_AXI_DW-1:0] S_AXI_WDATA,     // Write data
  input  wire logic [3:0]                    S_AXI_WSTRB,      // Write strobes
  input  wire logic                          S_AXI_WVALID,     // Write data valid
  output logic                               S_AXI_WREADY,     // Write data ready
  output logic [1:0]                         S_AXI_BRESP,      // Write response
  output logic                               S_AXI_BVALID,     // Write response valid
  input  wire logic                          S_AXI_BREADY,     // Write response ready
  input  wire logic [mis_pkg::MIS_AXI_AW-1:0] S_AXI_ARADDR,    // Read address
  input  wire logic                          S_AXI_ARVALID,    // Read address valid
  output logic                               S_AXI_ARREADY,    // Read address ready
  output logic [mis_pkg::MIS_AXI_DW-1:0]     S_AXI_RDATA,      // Read data
  output logic [1:0]                         S_AXI_RRESP,      // Read response
  output logic                               S_AXI_RVALID,     // Read data valid
  input  wire logic                          S_AXI_RREADY,     // Read data ready
  // Peripheral events, same clock
  input  wire mis_pkg::mis_evt_s             TMR_EVT,          // Timer counts, watchdog
  input  wire logic                          CFG_WDT_IRQ_MODE, // Watchdog acts by interrupt
  // Asynchronous inputs
  input  wire logic [PB_W-1:0]               PORTB_PIN,        // Port B pin levels
  input  wire logic                          COMPARATOR_OUT,   // Live comparator output
  // Core sequencer
  input  wire logic                          IRQ_TAKEN,        // Core takes request, pulse
  output logic                               IRQ_REQ,          // Service request level
  output logic [11:0]                        IRQ_VECTOR,       // Fetch address when taken
  output logic                               GLOBAL_IRQ_ENABLE // Global enable state
);

  // ----------------
  // Declarations
  // ----------------
  logic [MIS_NSRC-1:0]   flags_r;
  logic [MIS_NSRC-1:0]   flags_nxt;
  logic [MIS_NSRC-1:0]   flag_set;
  logic [MIS_NSRC-1:0]   flag_clr;
  logic [MIS_NSRC-1:0]   src_enable_r;
  logic                  global_irq_enable_r;
  logic                  external_irq_select_r;
  logic                  external_edge_polarity_r;
  logic [PB_W-1:0]       portb_pin_change_enable_r;
  logic [PB_W-1:0]       portb_input_mask_r;
  logic [6:0]            osc_comparator_control_reg_r;
  logic                  cmp_copy_r;
  logic [7:0]            tmr0_prev_r;
  logic [7:0]            tmr1_prev_r;
  logic [7:0]            tmr2_prev_r;
  logic [PB_W-1:0]       pb_new;
  logic [PB_W-1:0]       pb_old;
  logic                  cmp_new;
  logic                  cmp_old;
  logic [PB_W-1:0]       pb_change;
  logic                  portb_pin_zero_rise;
  logic                  portb_pin_zero_fall;
  logic                  aw_held_r;
  logic                  w_held_r;
  logic [MIS_AXI_AW-1:0] aw_addr_r;
  logic [MIS_AXI_DW-1:0] w_data_r;
  logic [3:0]            w_strb_r;
  logic                  do_write;
  logic                  wr_lane0;
  logic                  wr_lane1;
  logic                  rd_take;
  logic [MIS_AXI_DW-1:0] rd_data;
  logic                  rd_hit;
  logic                  wr_hit;
  logic                  pending;

  // ----------------
  // Pin synchronisation
  // ----------------
  // Port B pins through three stages
  mis_sync #(
    .W      (PB_W)
  ) u_pb_sync (
    .clk    (CLK),
    .reset  (RESET),
    .ce     (CE),
    .din    (PORTB_PIN),
    .new_q  (pb_new),                                             // R19
    .old_q  (pb_old)
  );

  // Comparator output through three stages
  mis_sync #(
    .W      (1)
  ) u_cmp_sync (
    .clk    (CLK),
    .reset  (RESET),
    .ce     (CE),
    .din    (COMPARATOR_OUT),
    .new_q  (cmp_new),
    .old_q  (cmp_old)
  );

  // ----------------
  // Event detection
  // ----------------
  // Per-pin level change, pin zero muted by external select
  for (genvar i = 0; i < PB_W; i++) begin : g_pbchg
    if (i == 0) begin : g_pin0
      assign pb_change[i] = (pb_new[i] ^ pb_old[i]) & portb_input_mask_r[i]
                            & portb_pin_change_enable_r[i]
                            & ~external_irq_select_r;            // R11
    end else begin : g_pinx
      assign pb_change[i] = (pb_new[i] ^ pb_old[i]) & portb_input_mask_r[i]
                            & portb_pin_change_enable_r[i];      // R9
    end
  end

  // Edges of pin zero after synchronisation
  assign portb_pin_zero_rise = pb_new[0] & ~pb_old[0];
  assign portb_pin_zero_fall = ~pb_new[0] & pb_old[0];

  // Hardware set terms for each flag
  always_comb begin
    flag_set = '0;
    flag_set[MIS_F_T0] = ((tmr0_prev_r == MIS_CNT_MAX) && (TMR_EVT.tmr0_count == MIS_CNT_MIN))
                      || ((tmr0_prev_r == MIS_CNT_MIN)
                          && (TMR_EVT.tmr0_count == MIS_CNT_MAX));   // R1
    flag_set[MIS_F_T1] = (tmr1_prev_r == MIS_CNT_MAX)
                      && (TMR_EVT.tmr1_count == MIS_CNT_MIN);         // R3
    flag_set[MIS_F_T2] = (tmr2_prev_r == MIS_CNT_MAX)
                      && (TMR_EVT.tmr2_count == MIS_CNT_MIN);         // R5
    flag_set[MIS_F_WDT] = TMR_EVT.wdt_timeout & CFG_WDT_IRQ_MODE; // R7
    flag_set[MIS_F_PB]  = |pb_change;                             // R9
    flag_set[MIS_F_EXT] = external_irq_select_r
                        & (external_edge_polarity_r ? portb_pin_zero_rise
                                                    : portb_pin_zero_fall); // R12
    flag_set[MIS_F_CMP] = cmp_old ^ cmp_copy_r;                    // R14
  end

  // Previous timer counts for wrap detection
  always_ff @(posedge CLK) begin
    if (RESET) begin
      tmr0_prev_r <= MIS_CNT_MIN;
      tmr1_prev_r <= MIS_CNT_MIN;
      tmr2_prev_r <= MIS_CNT_MIN;
    end else if (CE) begin
      tmr0_prev_r <= TMR_EVT.tmr0_count;
      tmr1_prev_r <= TMR_EVT.tmr1_count;
      tmr2_prev_r <= TMR_EVT.tmr2_count;
    end
  end

  // ----------------
  // Sticky flags
  // ----------------
  // Zero written to a flag bit clears it; ones are ignored
  always_comb begin
    flag_clr = '0;
    if (do_write && wr_lane0 && (aw_addr_r == MIS_OFS_FLAGS)) begin
      flag_clr = ~w_data_r[MIS_NSRC-1:0];                          // R17
    end
    flags_nxt = (flags_r & ~flag_clr) | flag_set;                  // R20
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      flags_r <= MIS_FLAGS_RST;
    end else if (CE) begin
      flags_r <= flags_nxt;                                        // R17
    end
  end

  // ----------------
  // Comparator registered copy
  // ----------------
  // Refreshed by a read of the oscillator/comparator register
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cmp_copy_r <= 1'b0;
    end else if (CE && rd_take && (S_AXI_ARADDR == MIS_OFS_OSCCMP)) begin
      cmp_copy_r <= cmp_old;                                       // R16
    end
  end

  // ----------------
  // Request to the core
  // ----------------
  // Each flag gated by its own enable and the global enable
  assign pending = |(flags_r & src_enable_r);                      // R2 R4 R6 R8 R10 R13 R15

  always_ff @(posedge CLK) begin
    if (RESET) begin
      IRQ_REQ    <= 1'b0;
      IRQ_VECTOR <= MIS_HW_VECTOR;
    end else if (CE) begin
      IRQ_REQ    <= pending & global_irq_enable_r & ~IRQ_TAKEN;   // R2 R4 R6 R8 R10 R13 R15
      IRQ_VECTOR <= MIS_HW_VECTOR;                                 // R18
    end
  end

  // Global enable: core take clears it ahead of a software set
  always_ff @(posedge CLK) begin
    if (RESET) begin
      global_irq_enable_r <= 1'b0;
    end else if (CE) begin
      if (IRQ_TAKEN) begin
        global_irq_enable_r <= 1'b0;                               // R18
      end else if (do_write && wr_lane0 && (aw_addr_r == MIS_OFS_ENABLE)) begin
        global_irq_enable_r <= w_data_r[MIS_EN_GIE];
      end
    end
  end

  // Mirror of the global enable
  always_ff @(posedge CLK) begin
    if (RESET) begin
      GLOBAL_IRQ_ENABLE <= 1'b0;
    end else if (CE) begin
      GLOBAL_IRQ_ENABLE <= IRQ_TAKEN ? 1'b0 : global_irq_enable_r;
    end
  end

  // ----------------
  // Software registers
  // ----------------
  assign wr_lane0 = w_strb_r[0];
  assign wr_lane1 = w_strb_r[1];

  // Enables, configuration, port B setup and oscillator control bits
  always_ff @(posedge CLK) begin
    if (RESET) begin
      src_enable_r                 <= MIS_FLAGS_RST;
      external_irq_select_r        <= 1'b0;
      external_edge_polarity_r     <= 1'b0;
      portb_pin_change_enable_r    <= '0;
      portb_input_mask_r           <= '0;
      osc_comparator_control_reg_r <= MIS_OC_RST;
    end else if (CE && do_write) begin
      case (aw_addr_r)
        MIS_OFS_ENABLE: begin
          if (wr_lane0) src_enable_r <= w_data_r[MIS_NSRC-1:0];
        end
        MIS_OFS_CONFIG: begin
          if (wr_lane0) begin
            external_irq_select_r    <= w_data_r[MIS_C_EIS];
            external_edge_polarity_r <= w_data_r[MIS_C_EDGE];
          end
        end
        MIS_OFS_PORTB: begin
          if (wr_lane0) portb_pin_change_enable_r <= w_data_r[PB_W-1:0];
          if (wr_lane1) portb_input_mask_r <= w_data_r[MIS_PB_DIR_LSB +: PB_W];
        end
        MIS_OFS_OSCCMP: begin
          if (wr_lane0) osc_comparator_control_reg_r <= w_data_r[6:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Write address decode
  always_comb begin
    case (aw_addr_r)
      MIS_OFS_FLAGS, MIS_OFS_ENABLE, MIS_OFS_CONFIG,
      MIS_OFS_PORTB, MIS_OFS_OSCCMP, MIS_OFS_STATUS: wr_hit = 1'b1;
      default:                                        wr_hit = 1'b0;
    endcase
  end

  // Read mux
  always_comb begin
    rd_data = '0;
    rd_hit  = 1'b1;
    case (S_AXI_ARADDR)
      MIS_OFS_FLAGS:  rd_data[MIS_NSRC-1:0] = flags_r;
      MIS_OFS_ENABLE: begin
        rd_data[MIS_NSRC-1:0] = src_enable_r;
        rd_data[MIS_EN_GIE]   = global_irq_enable_r;
      end
      MIS_OFS_CONFIG: begin
        rd_data[MIS_C_EIS]  = external_irq_select_r;
        rd_data[MIS_C_EDGE] = external_edge_polarity_r;
      end
      MIS_OFS_PORTB: begin
        rd_data[PB_W-1:0]                = portb_pin_change_enable_r;
        rd_data[MIS_PB_DIR_LSB +: PB_W]  = portb_input_mask_r;
      end
      MIS_OFS_OSCCMP: begin
        rd_data[6:0]        = osc_comparator_control_reg_r;
        rd_data[MIS_OC_CMP] = cmp_old;
      end
      MIS_OFS_STATUS: begin
        rd_data[MIS_NSRC-1:0] = flags_r & src_enable_r;
        rd_data[MIS_EN_GIE]   = IRQ_REQ;
      end
      default:        rd_hit = 1'b0;
    endcase
  end

  // ----------------
  // AXI4-Lite write channels
  // ----------------
  assign do_write = aw_held_r & w_held_r & ~S_AXI_BVALID;

  // Address and data accepted in either order
  always_ff @(posedge CLK) begin
    if (RESET) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      aw_addr_r     <= '0;
      w_data_r      <= '0;
      w_strb_r      <= '0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
    end else if (CE) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_r     <= 1'b1;
        aw_addr_r     <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_AWREADY <= 1'b1;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_r     <= 1'b1;
        w_data_r     <= S_AXI_WDATA;
        w_strb_r     <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge CLK) begin
    if (RESET) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= MIS_RESP_OKAY;
    end else if (CE) begin
      if (do_write) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_hit ? MIS_RESP_OKAY : MIS_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // ----------------
  // AXI4-Lite read channels
  // ----------------
  assign rd_take = S_AXI_ARVALID & S_AXI_ARREADY;

  // Data captured at the address handshake
  always_ff @(posedge CLK) begin
    if (RESET) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= '0;
      S_AXI_RRESP   <= MIS_RESP_OKAY;
    end else if (CE) begin
      if (rd_take) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RDATA   <= rd_data;
        S_AXI_RRESP   <= rd_hit ? MIS_RESP_OKAY : MIS_RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID  <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// >>> mis_pkg.sv
// Package: register map, field layout and carrier types of the interrupt source logic
package mis_pkg;

  // ----------------
  // Bus and register map
  // ----------------
  localparam int          MIS_AXI_AW      = 8;
  localparam int          MIS_AXI_DW      = 32;
  localparam logic [7:0]  MIS_OFS_FLAGS   = 8'h00;
  localparam logic [7:0]  MIS_OFS_ENABLE  = 8'h04;
  localparam logic [7:0]  MIS_OFS_CONFIG  = 8'h08;
  localparam logic [7:0]  MIS_OFS_PORTB   = 8'h0C;
  localparam logic [7:0]  MIS_OFS_OSCCMP  = 8'h10;
  localparam logic [7:0]  MIS_OFS_STATUS  = 8'h14;
  localparam logic [1:0]  MIS_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  MIS_RESP_SLVERR = 2'h2;

  // ----------------
  // Request flag positions, shared by flag and enable registers
  // ----------------
  localparam int          MIS_NSRC        = 7;
  localparam int          MIS_F_T0        = 0;
  localparam int          MIS_F_T1        = 1;
  localparam int          MIS_F_T2        = 2;
  localparam int          MIS_F_PB        = 3;
  localparam int          MIS_F_EXT       = 4;
  localparam int          MIS_F_CMP       = 5;
  localparam int          MIS_F_WDT       = 6;
  localparam int          MIS_EN_GIE      = 7;

  // Config register fields
  localparam int          MIS_C_EIS       = 0;
  localparam int          MIS_C_EDGE      = 1;
  // Port B register fields: change enables low byte, input mask next byte
  localparam int          MIS_PB_W        = 8;
  localparam int          MIS_PB_DIR_LSB  = 8;
  // Oscillator and comparator control register: live comparator bit
  localparam int          MIS_OC_CMP      = 7;
  localparam logic [6:0]  MIS_OC_RST      = 7'h01;

  // ----------------
  // Timer limit values and vector
  // ----------------
  localparam logic [7:0]  MIS_CNT_MIN     = 8'h00;
  localparam logic [7:0]  MIS_CNT_MAX     = 8'hFF;
  localparam logic [11:0] MIS_HW_VECTOR   = 12'h008;
  localparam logic [6:0]  MIS_FLAGS_RST   = 7'h00;
  localparam logic [7:0]  MIS_BYTE_RST    = 8'h00;

  // ----------------
  // Carrier of on-chip peripheral events, same clock domain
  // ----------------
  typedef struct packed {
    logic [7:0] tmr0_count;
    logic [7:0] tmr1_count;
    logic [7:0] tmr2_count;
    logic       wdt_timeout;
  } mis_evt_s;

endpackage

// >>> mis_sync.sv
// Three-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
`default_nettype none
module mis_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,     // System clock
  input  wire logic         reset,   // Synchronous reset, high
  input  wire logic         ce,      // Clock enable
  input  wire logic [W-1:0] din,     // Asynchronous input
  output logic      [W-1:0] new_q,   // Second stage
  output logic      [W-1:0] old_q    // Third stage
);

  logic [W-1:0] meta_r;

  // ----------------
  // Per-bit flop chain; first stage only feeds second
  // ----------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (reset) begin
        meta_r[i] <= 1'b0;
        new_q[i]  <= 1'b0;
        old_q[i]  <= 1'b0;
      end else if (ce) begin
        meta_r[i] <= din[i];
        new_q[i]  <= meta_r[i];
        old_q[i]  <= new_q[i];
      end
    end
  end

endmodule
`default_nettype wire

// >>> mis_irq_monitor.sv
// Checker of request and bus timing at the interrupt source ports
`timescale 1ns/10ps
`default_nettype none
module mis_irq_monitor (
  input wire logic        CLK,               // Clock
  input wire logic        RESET,             // Reset, high
  input wire logic        CE,                // Clock enable
  input wire logic        S_AXI_AWVALID,     // Aw valid
  input wire logic        S_AXI_AWREADY,     // Aw ready
  input wire logic        S_AXI_WVALID,      // W valid
  input wire logic        S_AXI_WREADY,      // W ready
  input wire logic        S_AXI_BVALID,      // B valid
  input wire logic        S_AXI_BREADY,      // B ready
  input wire logic        S_AXI_ARVALID,     // Ar valid
  input wire logic        S_AXI_ARREADY,     // Ar ready
  input wire logic        S_AXI_RVALID,      // R valid
  input wire logic        IRQ_TAKEN,         // Core takes
  input wire logic        IRQ_REQ,           // Request
  input wire logic [11:0] IRQ_VECTOR,        // Vector
  input wire logic        GLOBAL_IRQ_ENABLE  // Global enable
);
  // ----------------
  // Properties
  // ----------------
  // Frozen cycles abandon any attempt in flight
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET || !CE);
  sequence s_wtake;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_rtake;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  a_vector_fixed: assert property (IRQ_VECTOR == 12'h008)
    else $error("vector not fixed");
  a_taken_clears: assert property (IRQ_TAKEN |=> !GLOBAL_IRQ_ENABLE && !IRQ_REQ)
    else $error("take left request or global enable");
  a_req_needs_gie: assert property (IRQ_REQ |-> GLOBAL_IRQ_ENABLE)
    else $error("request without global enable");
  a_reset_idle: assert property ($fell(RESET) |-> !IRQ_REQ && !GLOBAL_IRQ_ENABLE
    && S_AXI_AWREADY && !S_AXI_BVALID)
    else $error("not idle after reset");
  a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped");
  a_write_lat: assert property (s_wtake |=> !S_AXI_BVALID ##1 S_AXI_BVALID)
    else $error("write response late");
  a_read_lat: assert property (s_rtake |=> S_AXI_RVALID)
    else $error("read data late");
  a_aw_blocked: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write accepted while response pending");
endmodule
bind mis_irq_top mis_irq_monitor mon_u (
  .CLK(CLK), .RESET(RESET), .CE(CE), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .IRQ_TAKEN(IRQ_TAKEN),
  .IRQ_REQ(IRQ_REQ), .IRQ_VECTOR(IRQ_VECTOR), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE));
`default_nettype wire

// >>> mis_core_model.sv
// Core sequencer model that takes a pending request after a delay
`timescale 1ns/10ps
`default_nettype none
module mis_core_model #(
  parameter int DLY = 3
) (
  input  wire logic clk,      // Clock
  input  wire logic reset,    // Reset, high
  input  wire logic irq_req,  // Request level
  input  wire logic take_en,  // Core accepts requests
  output logic      irq_taken // One-cycle take pulse
);
  int cnt;
  // Count request cycles, pulse once when the delay runs out
  always_ff @(posedge clk) begin
    if (reset || !irq_req || !take_en) begin
      cnt       <= 0;
      irq_taken <= 1'b0;
    end else begin
      cnt       <= cnt + 1;
      irq_taken <= (cnt == DLY);
    end
  end
endmodule
`default_nettype wire

// >>> mcu_interrupt_source_logic_tb.sv
// Testbench of the interrupt source logic with a core model
`timescale 1ns/10ps
`default_nettype none
module mcu_interrupt_source_logic_tb;
  import mis_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0;
  logic        rre = 1'b0, wmode = 1'b0, cmp = 1'b0, take_en = 1'b0;
  logic        tk, req, global_irq_enable, awr, wrd, bv, arr, rv;
  logic [7:0]  awa = '0, ara = '0, pb = '0;
  logic [31:0] wd = '0, rdt, d;
  logic [1:0]  br, rr, resp;
  logic [11:0] vec;
  mis_evt_s    evt = '{8'h10, 8'h10, 8'h10, 1'b0};
  int          err_total = 0, n_tests = 0, cyc_n = 0;
  always #2 clk = ~clk;
  mis_irq_top dut_u (
    .CLK(clk), .RESET(rst), .CE(1'b1), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrd), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdt),
    .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .TMR_EVT(evt),
    .CFG_WDT_IRQ_MODE(wmode), .PORTB_PIN(pb), .COMPARATOR_OUT(cmp), .IRQ_TAKEN(tk),
    .IRQ_REQ(req), .IRQ_VECTOR(vec), .GLOBAL_IRQ_ENABLE(global_irq_enable));
  mis_core_model #(.DLY(3)) core_u (
    .clk(clk), .reset(rst), .irq_req(req), .take_en(take_en), .irq_taken(tk));
  // ----------------
  // Bus and compare tasks
  // ----------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Write: address and data together, ready sampled before each edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    awa <= a;
    wd  <= v;
    awv <= 1'b1;
    wv  <= 1'b1;
    bre <= 1'b1;
    do @(negedge clk); while (!awr);
    @(posedge clk);
    awv <= 1'b0;
    wv  <= 1'b0;
    do @(negedge clk); while (!bv);
    @(posedge clk);
    bre <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do @(negedge clk); while (!arr);
    @(posedge clk);
    arv <= 1'b0;
    do begin
      @(negedge clk);
      d    = rdt;
      resp = rr;
    end while (!rv);
    @(posedge clk);
    rre <= 1'b0;
    chk(n, e, d);
  endtask
  task automatic fl(input logic [31:0] e);
    rchk("flags", MIS_OFS_FLAGS, e);
  endtask
  // Pin step, settle through the synchroniser, check and clear
  task automatic pin(input logic [7:0] v, input logic [31:0] e);
    @(posedge clk);
    pb <= v;
    cyc(6);
    fl(e);
    wr(MIS_OFS_FLAGS, '0);
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_reset;
    rchk("enable", MIS_OFS_ENABLE, '0);
    rchk("osccmp", MIS_OFS_OSCCMP, 32'(MIS_OC_RST));
    chk("vector", 32'h0000_0008, 32'(vec));
    rchk("unmapped", 8'h40, '0);
    chk("unmapped resp", 32'(MIS_RESP_SLVERR), 32'(resp));
  endtask
  task automatic t_timers;
    @(posedge clk);
    evt.tmr0_count <= 8'h00;
    evt.tmr1_count <= 8'h0F;
    evt.tmr2_count <= 8'hFF;
    cyc(2);
    fl(32'h0000_0000);
    @(posedge clk);
    evt.tmr0_count <= 8'hFF;
    evt.tmr1_count <= 8'hFF;
    cyc(2);
    fl(32'h0000_0001);
    @(posedge clk);
    evt.tmr1_count <= 8'h00;
    evt.tmr2_count <= 8'h00;
    cyc(2);
    fl(32'h0000_0007);
    wr(MIS_OFS_FLAGS, 32'h0000_007F);
    fl(32'h0000_0007);
    wr(MIS_OFS_FLAGS, '0);
    fl(32'h0000_0000);
  endtask
  task automatic t_wdt;
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      wmode           <= 1'(m);
      evt.wdt_timeout <= 1'b1;
      @(posedge clk);
      evt.wdt_timeout <= 1'b0;
      fl(m ? 32'h0000_0040 : 32'h0000_0000);
    end
    wr(MIS_OFS_FLAGS, '0);
  endtask
  task automatic t_portb;
    wr(MIS_OFS_PORTB, 32'h0000_FF02);
    pin(8'h04, 32'h0000_0000);
    pin(8'h06, 32'h0000_0008);
    pin(8'h04, 32'h0000_0008);
    wr(MIS_OFS_PORTB, 32'h0000_FD03);
    pin(8'h06, 32'h0000_0000);
    wr(MIS_OFS_CONFIG, 32'h0000_0003);
    pin(8'h07, 32'h0000_0010);
    pin(8'h06, 32'h0000_0000);
    wr(MIS_OFS_CONFIG, 32'h0000_0001);
    pin(8'h07, 32'h0000_0000);
    pin(8'h06, 32'h0000_0010);
    wr(MIS_OFS_CONFIG, '0);
  endtask
  task automatic t_cmp;
    @(posedge clk);
    cmp <= 1'b1;
    cyc(6);
    fl(32'h0000_0020);
    wr(MIS_OFS_FLAGS, '0);
    fl(32'h0000_0020);
    rchk("osccmp live", MIS_OFS_OSCCMP, 32'h0000_0081);
    wr(MIS_OFS_FLAGS, '0);
    fl(32'h0000_0000);
  endtask
  task automatic t_irq;
    @(posedge clk);
    evt.tmr0_count <= 8'h00;
    wr(MIS_OFS_ENABLE, 32'h0000_0001);
    cyc(3);
    chk("req without global", '0, 32'(req));
    rchk("status", MIS_OFS_STATUS, 32'h0000_0001);
    take_en <= 1'b1;
    wr(MIS_OFS_ENABLE, 32'h0000_0081);
    do @(negedge clk); while (!req);
    chk("global while req", 32'h1, 32'(global_irq_enable));
    do @(negedge clk); while (!tk);
    @(negedge clk);
    chk("global after take", '0, 32'(global_irq_enable));
    chk("req after take", '0, 32'(req));
    take_en <= 1'b0;
    fl(32'h0000_0001);
    wr(MIS_OFS_FLAGS, '0);
  endtask
  // ----------------
  // Sequence, timeout and verdict
  // ----------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Hang guard well beyond the whole sequence
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    cyc(3);
    rst <= 1'b0;
    t_reset();
    t_timers();
    t_wdt();
    t_portb();
    t_cmp();
    t_irq();
    stop_test();
  end
endmodule
`default_nettype wire
